/* File: hdl/ctr_pkg.sv */
/*
 * package for the cache test register block: register indices, field
 * positions, line states and operation codes.
 * assumes a 32-bit plain register port and a single core clock.
 */
package ctr_pkg;

    // ---------------------------------------------------------------
    // register indices
    // ---------------------------------------------------------------
    localparam logic [1:0] CTR_ADDR_DATA = 2'h0;
    localparam logic [1:0] CTR_ADDR_STATUS = 2'h1;
    localparam logic [1:0] CTR_ADDR_CONTROL = 2'h2;

    // ---------------------------------------------------------------
    // status register fields
    // ---------------------------------------------------------------
    localparam int CTR_ST_TAG_LSB = 12;
    localparam int CTR_ST_SEL_LSB = 29;
    localparam int CTR_ST_WAY0_LSB = 20;
    localparam int CTR_ST_ZERO_BIT = 11;
    localparam int CTR_ST_VALID_BIT = 10;
    localparam int CTR_ST_REPL_LSB = 7;
    localparam int CTR_ST_VSET_LSB = 3;

    // ---------------------------------------------------------------
    // control register fields
    // ---------------------------------------------------------------
    localparam int CTR_CT_EXT_BIT = 19;
    localparam int CTR_CT_STATE_LSB = 17;
    localparam int CTR_CT_INDEX_LSB = 4;
    localparam int CTR_CT_ENTRY_LSB = 2;
    localparam int CTR_CT_OP_LSB = 0;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [31:0] CTR_STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] CTR_CONTROL_RESET = 32'h0000_0000;

    // line state coding
    typedef enum logic [1:0] {
        CTR_INVALID = 2'h0,
        CTR_EXCLUSIVE = 2'h1,
        CTR_MODIFIED = 2'h2,
        CTR_SHARED = 2'h3
    } ctr_state_t;

    // operation codes
    typedef enum logic [1:0] {
        CTR_OP_BUFFER = 2'h0,
        CTR_OP_WRITE = 2'h1,
        CTR_OP_READ = 2'h2,
        CTR_OP_FLUSH = 2'h3
    } ctr_op_t;

    // register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ctr_req_t;

endpackage

/* File: hdl/ctr_cache_test.sv */
/*
 * cache test register block: data, status and control registers that
 * read, write and flush a four-way cache array of tags, states,
 * replacement bits and line data.
 * assumes the register port runs on clk and the policy pin is
 * asynchronous to it.
 */
`timescale 1ns/1ps

// Functional notes
// - policy pin caught when reset falls
// - tag field present unless extension set
// - selected way state shown by extension
// - per-way states shown in bits 27-20
// - state coding invalid exclusive modified shared
// - bit 11 reads zero on look-up
// - valid bit copies way; writes only write-through
// - replacement bits read-only, cleared by reset and flush
// - valid set bits read-only, state-derived
// - extension bit only in write-back mode
// - write-back cache write takes set state
// - index selects one of 256 lines
// - entry selects way or doubleword
// - operation code field decoded
// - control read code starts cache read
// - cache read fills 128-bit read buffer
// - buffer code data read returns doubleword
// - buffer code data write fills slot
// - cache write commits fill buffer and tag
// - status bits 9:0 ignored on write
// - flush clears replacement, valid, state
module ctr_cache_test
    import ctr_pkg::*;
#(
    parameter int LINES = 256,
    parameter int WAYS = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // policy strap
    input wire logic cache_policy_pin,
    // register port
    input wire logic [1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // mode seen by the rest of the core
    output logic write_back_mode
);

    // ---------------------------------------------------------------
    // parameter check
    // ---------------------------------------------------------------
    // refuse sizes the fixed field widths cannot serve
    generate
        if (LINES != 256 || WAYS != 4)
        begin : g_bad_param
            $error("ctr_cache_test: only 256 lines of 4 ways supported");
        end
    endgenerate

    ctr_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // ---------------------------------------------------------------
    // policy pin synchroniser and strap capture
    // ---------------------------------------------------------------
    logic pol_s1_q, pol_s2_q, in_reset_q, wb_q;

    // two flops before any logic looks at the pin
    always_ff @(posedge clk)
    begin
        pol_s1_q <= cache_policy_pin;
        pol_s2_q <= pol_s1_q;
    end

    // catch the level on the first edge after reset falls
    always_ff @(posedge clk)
    begin
        in_reset_q <= reset;
        if (reset)
            wb_q <= 1'b0;
        else if (in_reset_q)
            wb_q <= pol_s2_q;
    end
    assign write_back_mode = wb_q;

    // ---------------------------------------------------------------
    // cache arrays
    // ---------------------------------------------------------------
    logic [19:0] tag_mem [LINES][WAYS];
    logic [127:0] data_mem [LINES][WAYS];
    logic [1:0] state_q [LINES][WAYS];
    logic [2:0] repl_q [LINES];
    logic [127:0] fill_q, rbuf_q;
    logic [31:0] status_q, control_q, rdata_q;
    logic lookup_q;

    // ---------------------------------------------------------------
    // decode of the incoming request
    // ---------------------------------------------------------------
    wire wr_data = req.wr && req.addr == CTR_ADDR_DATA;
    wire wr_stat = req.wr && req.addr == CTR_ADDR_STATUS;
    wire wr_ctrl = req.wr && req.addr == CTR_ADDR_CONTROL;
    wire [1:0] new_op = req.wdata[CTR_CT_OP_LSB +: 2];
    wire [7:0] new_idx = req.wdata[CTR_CT_INDEX_LSB +: 8];
    wire [1:0] new_ent = req.wdata[CTR_CT_ENTRY_LSB +: 2];
    wire [1:0] new_set = req.wdata[CTR_CT_STATE_LSB +: 2];
    wire do_read = wr_ctrl && new_op == CTR_OP_READ;
    wire do_write = wr_ctrl && new_op == CTR_OP_WRITE;
    wire do_flush = wr_ctrl && new_op == CTR_OP_FLUSH;
    wire ext = wb_q && control_q[CTR_CT_EXT_BIT];
    wire [1:0] cur_op = control_q[CTR_CT_OP_LSB +: 2];
    wire [1:0] cur_ent = control_q[CTR_CT_ENTRY_LSB +: 2];
    wire [1:0] sel_way = control_q[CTR_CT_STATE_LSB +: 2];

    // control bits writable per mode; extension and state only in wb
    wire [31:0] ctrl_mask = wb_q ? 32'h000E_0FFF : 32'h0000_0FFF;

    // valid flag of a way: any non-invalid state
    function automatic logic is_valid(input logic [1:0] st);
        return st != CTR_INVALID;
    endfunction

    // state written by a cache write, per mode
    wire [1:0] wr_state = wb_q ? new_set
        : (status_q[CTR_ST_VALID_BIT] ? CTR_EXCLUSIVE : CTR_INVALID);

    // ---------------------------------------------------------------
    // look-up result for the addressed set
    // ---------------------------------------------------------------
    logic [3:0] vset;
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_way
            assign vset[g] = is_valid(state_q[new_idx][g]);
        end
    endgenerate

    // status word loaded by a cache read
    wire [31:0] rd_status = {tag_mem[new_idx][new_ent], 1'b0,
        vset[new_ent], repl_q[new_idx], vset, 3'h0};

    // ---------------------------------------------------------------
    // control and status registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            control_q <= CTR_CONTROL_RESET;
        else if (wr_ctrl)
            control_q <= req.wdata & ctrl_mask;
    end

    // look-up view lasts until software writes status or writes control with a non-read code
    always_ff @(posedge clk)
    begin
        if (reset)
            lookup_q <= 1'b0;
        else if (do_read)
            lookup_q <= 1'b1;
        else if (wr_stat || wr_ctrl)
            lookup_q <= 1'b0;
    end

    // status: only tag, bit 11 and, in write-through, valid are software-writable
    always_ff @(posedge clk)
    begin
        if (reset)
            status_q <= CTR_STATUS_RESET;
        else if (do_read)
            status_q <= rd_status;
        else if (wr_stat)
            status_q <= {req.wdata[31:11],
                wb_q ? status_q[10] : req.wdata[10],
                status_q[9:0]};
    end

    // ---------------------------------------------------------------
    // cache array updates
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (do_write)
        begin
            tag_mem[new_idx][new_ent] <= status_q[31:12];
            data_mem[new_idx][new_ent] <= fill_q;
        end
    end

    // line states and replacement bits
    always_ff @(posedge clk)
    begin
        if (reset || do_flush)
        begin
            for (int l = 0; l < LINES; l++)
            begin
                repl_q[l] <= 3'h0;
                for (int w = 0; w < WAYS; w++)
                    state_q[l][w] <= CTR_INVALID;
            end
        end
        else if (do_write)
            state_q[new_idx][new_ent] <= wr_state;
    end

    // ---------------------------------------------------------------
    // line buffers
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            fill_q <= 128'h0;
        else if (wr_data && cur_op == CTR_OP_BUFFER)
            fill_q[32*cur_ent +: 32] <= req.wdata;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            rbuf_q <= 128'h0;
        else if (do_read)
            rbuf_q <= data_mem[new_idx][new_ent];
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    logic [1:0] lk_sel;
    assign lk_sel = sel_way;
    // per-way states of the set under look-up, way 3 on top
    wire [7:0] lk_states = {state_q[control_q[11:4]][3],
        state_q[control_q[11:4]][2], state_q[control_q[11:4]][1],
        state_q[control_q[11:4]][0]};
    wire [31:0] ext_view = {1'b0, lk_states[2*lk_sel +: 2], 1'b0,
        lk_states, 8'h0, status_q[11:0]} & {32'hFFFF_F7FF
        | {20'h0, ~lookup_q, 11'h0}};
    wire [31:0] std_view = lookup_q
        ? {status_q[31:12], 1'b0, status_q[10:0]}
        : status_q;
    wire [31:0] stat_view = ext ? ext_view : std_view;

    wire [31:0] data_view = cur_op == CTR_OP_BUFFER
        ? rbuf_q[32*cur_ent +: 32] : 32'h0;

    // read data stand in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (reset)
            rdata_q <= 32'h0;
        else if (!req.rd)
            rdata_q <= 32'h0;
        else if (req.addr == CTR_ADDR_DATA)
            rdata_q <= data_view;
        else if (req.addr == CTR_ADDR_STATUS)
            rdata_q <= stat_view;
        else if (req.addr == CTR_ADDR_CONTROL)
            rdata_q <= control_q;
        else
            rdata_q <= 32'h0;
    end
    assign rdata = rdata_q;

endmodule

/* File: testbench/ctr_chk.sv */
/* checker for the cache test register block.
   sees only the top module ports; bound from the testbench top. */
`timescale 1ns/1ps
module ctr_chk
    import ctr_pkg::*;
#(
    parameter int LINES = 256,
    parameter int WAYS = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // strap and register port
    input wire logic cache_policy_pin,
    input wire logic [1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic write_back_mode
);
    // read of the control register
    wire rd_ctl = rd && addr == CTR_ADDR_CONTROL;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // control write, then a read or look-up straight after
    sequence s_ctl_wr;
        wr && addr == CTR_ADDR_CONTROL;
    endsequence
    sequence s_lookup;
        wr && addr == CTR_ADDR_CONTROL && wdata[1:0] == CTR_OP_READ
        ##1 rd && addr == CTR_ADDR_STATUS;
    endsequence
    a_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property (rd && addr == 2'h3 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctl_wt_mask: assert property (rd_ctl && !write_back_mode
        |=> rdata[31:12] == 20'h0)
        else $error("write-through control upper bits not zero");
    a_ctl_wb_mask: assert property (rd_ctl && write_back_mode |=>
        rdata[31:20] == 12'h0 && rdata[16:12] == 5'h0)
        else $error("write-back control reserved bits not zero");
    a_status_low: assert property (rd && addr == CTR_ADDR_STATUS
        |=> rdata[2:0] == 3'h0)
        else $error("status low bits not zero");
    a_ctl_read_back: assert property (s_ctl_wr ##1 rd_ctl |=> rdata ==
        ($past(wdata, 2) & (write_back_mode ? 32'h000E0FFF : 32'h00000FFF)))
        else $error("control read back wrong");
    a_lookup_bit: assert property (s_lookup |=> rdata[11] == 1'h0)
        else $error("status bit 11 set on look-up");
    a_mode_hold: assert property (!$past(reset) && !$past(reset, 2)
        |-> $stable(write_back_mode))
        else $error("mode changed outside reset");
    a_mode_latch: assert property ($fell(reset)
        |=> write_back_mode == cache_policy_pin)
        else $error("mode not taken from strap");
endmodule

/* File: testbench/testbench.sv */
/* self-checking bench for the cache test register block.
   drives the register port itself; the checker is bound below. */
`timescale 1ns/1ps
module testbench
    import ctr_pkg::*;
;
    typedef struct packed {
        logic m;
        logic [1:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } ctr_tb_row_t;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic cache_policy_pin = 1'h1;
    logic [1:0] addr = 2'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [31:0] rdata;
    logic write_back_mode;
    logic [31:0] v;
    int error_cnt = 0;
    int comparisons = 0;
    // mode, address, written value, value read back
    ctr_tb_row_t rows [6] = '{
        '{1'h1, CTR_ADDR_STATUS, 32'hFFFFFFFF, 32'hFFFFF800},
        '{1'h1, CTR_ADDR_CONTROL, 32'hFFFFFFF0, 32'h000E0FF0},
        '{1'h1, 2'h3, 32'hFFFFFFFF, 32'h0},
        '{1'h0, CTR_ADDR_STATUS, 32'hFFFFFFFF, 32'hFFFFFC00},
        '{1'h0, CTR_ADDR_CONTROL, 32'hFFFFFFF0, 32'h00000FF0},
        '{1'h0, 2'h3, 32'hFFFFFFFF, 32'h0}};
    ctr_cache_test #(.LINES(256), .WAYS(4)) dut (.clk(clk), .reset(reset),
        .cache_policy_pin(cache_policy_pin), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .write_back_mode(write_back_mode));
    // clock
    initial
    begin
        forever #10 clk = ~clk;
    end
    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            error_cnt++;
        end
    endtask
    // one bus cycle; strobes stand until the next call
    task cyc(input logic w, input logic r, input logic [1:0] a,
        input logic [31:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    task rdr(input logic [1:0] a, output logic [31:0] d);
        cyc(1'h0, 1'h1, a, 32'h0);
        #1 d = rdata;
    endtask
    task wc(input logic [31:0] d);
        cyc(1'h1, 1'h0, CTR_ADDR_CONTROL, d);
    endtask
    task do_reset(input logic p);
        cache_policy_pin <= p;
        reset <= 1'h1;
        wr <= 1'h0;
        rd <= 1'h0;
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        repeat (2) @(posedge clk);
        check("mode", {31'h0, write_back_mode}, {31'h0, p});
    endtask
    task test_done;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog against a hung run
    initial
    begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        test_done;
    end
    // main sequence
    initial
    begin
        foreach (rows[i])
        begin
            if (rows[i].m !== write_back_mode)
                do_reset(rows[i].m);
            cyc(1'h1, 1'h0, rows[i].a, rows[i].d);
            rdr(rows[i].a, v);
            check("row", v, rows[i].e);
        end
        do_reset(1'h1);
        rdr(CTR_ADDR_STATUS, v);
        check("st_rst", v, CTR_STATUS_RESET);
        rdr(CTR_ADDR_CONTROL, v);
        check("ct_rst", v, CTR_CONTROL_RESET);
        cache_policy_pin <= 1'h0;
        wc(32'h3);
        for (int k = 0; k < 4; k++)
        begin
            wc(32'(k) << 2);
            cyc(1'h1, 1'h0, CTR_ADDR_DATA, 32'hA5000000 | 32'(k));
        end
        cyc(1'h1, 1'h0, CTR_ADDR_STATUS, 32'hABCDE3FF);
        wc(32'h000405A9);
        wc(32'h000005AA);
        rdr(CTR_ADDR_STATUS, v);
        check("lookup", v, 32'hABCDE420);
        wc(32'h000C05AA);
        rdr(CTR_ADDR_STATUS, v);
        check("states", v, 32'h42000420);
        for (int k = 0; k < 4; k++)
        begin
            wc(32'(k) << 2);
            rdr(CTR_ADDR_DATA, v);
            check("line", v, 32'hA5000000 | 32'(k));
        end
        wc(32'h3);
        wc(32'h000005AA);
        rdr(CTR_ADDR_STATUS, v);
        check("flush", v, 32'hABCDE000);
        check("pin", {31'h0, write_back_mode}, 32'h1);
        do_reset(1'h0);
        cyc(1'h1, 1'h0, CTR_ADDR_STATUS, 32'h12345400);
        wc(32'h00060015);
        wc(32'h00000016);
        rdr(CTR_ADDR_STATUS, v);
        check("wt_write", v, 32'h12345410);
        cyc(1'h0, 1'h0, 2'h0, 32'h0);
        test_done;
    end
endmodule
bind ctr_cache_test ctr_chk #(.LINES(LINES), .WAYS(WAYS)) u_chk (
    .clk(clk), .reset(reset), .cache_policy_pin(cache_policy_pin),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .write_back_mode(write_back_mode));
